// >>> shared/addr_wake_pkg.sv
package addr_wake_pkg;

  // Register byte offsets
  localparam logic [7:0] OWN_ADDR_OFS = 8'h44;
  localparam logic [7:0] ADDR_MASK_OFS = 8'h4c;
  localparam logic [7:0] WAKE_CTL_OFS = 8'h54;
  localparam logic [7:0] WAKE_STS_OFS = 8'h58;
  localparam logic [7:0] PROT_CTL_OFS = 8'h5c;
  localparam logic [7:0] IRQ_STS_OFS = 8'h60;
  localparam logic [7:0] IRQ_MSK_OFS = 8'h64;
  localparam logic [7:0] MATCH_STS_OFS = 8'h68;

  // Field positions and widths
  localparam int WAKE_EN_BIT = 0;
  localparam int WAKE_SEL_BIT = 1;
  localparam int WAKE_FLAG_BIT = 0;
  localparam int TEN_EN_BIT = 4;
  localparam int IRQ_MATCH_BIT = 0;
  localparam int IRQ_WAKE_BIT = 1;
  localparam int MATCH_ADDRESSED_BIT = 0;
  localparam int MATCH_RW_BIT = 1;
  localparam int ADDR_W = 10;
  localparam int IRQ_W = 2;

  // Reset values
  localparam logic [9:0] OWN_ADDR_RST = 10'h000;
  localparam logic [9:0] ADDR_MASK_RST = 10'h000;
  localparam logic [1:0] WAKE_CTL_RST = 2'h0;
  localparam logic [1:0] IRQ_RST = 2'h0;

  // Ten-bit first byte prefix and bit framing
  localparam logic [4:0] TEN_PREFIX = 5'h1e;
  localparam logic [3:0] DATA_BITS = 4'h8;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic start;
    logic stop;
    logic sda_edge;
    logic byte_valid;
    logic [7:0] data;
  } rx_event_t;

  typedef struct packed {
    logic wake_en;
    logic wake_sel;
    logic ten_en;
    logic [9:0] own;
    logic [9:0] mask;
  } match_cfg_t;

endpackage

// >>> rtl/i2c_byte_rx.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_byte_rx (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic scl_in,
  input wire logic sda_in,
  output addr_wake_pkg::rx_event_t rx_ev
);

  logic scl_s1_q, scl_s2_q, scl_p_q, sda_s1_q, sda_s2_q, sda_p_q;
  logic active_q, active_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] shift_q, shift_d;
  addr_wake_pkg::rx_event_t ev_q, ev_d;
  logic scl_rise;

  assign scl_rise = scl_s2_q & ~scl_p_q;
  assign rx_ev = ev_q;

  always_comb begin
    active_d = active_q;
    cnt_d = cnt_q;
    shift_d = shift_q;
    ev_d = '0;
    ev_d.data = ev_q.data;
    ev_d.sda_edge = sda_s2_q ^ sda_p_q;
    // Start and stop: data line moves while clock is high
    ev_d.start = scl_s2_q & scl_p_q & sda_p_q & ~sda_s2_q;
    ev_d.stop = scl_s2_q & scl_p_q & ~sda_p_q & sda_s2_q;
    if (ev_d.start) begin
      active_d = 1'b1;
      cnt_d = 4'h0;
    end else if (ev_d.stop) begin
      active_d = 1'b0;
    end else if (scl_rise && active_q) begin
      if (cnt_q < addr_wake_pkg::DATA_BITS) begin
        shift_d = {shift_q[6:0], sda_s2_q};
        cnt_d = cnt_q + 4'h1;
        if (cnt_q == addr_wake_pkg::DATA_BITS - 4'h1) begin
          ev_d.byte_valid = 1'b1;
          ev_d.data = {shift_q[6:0], sda_s2_q};
        end
      end else begin
        // Acknowledge slot closes the byte
        cnt_d = 4'h0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      sda_p_q <= 1'b1;
      active_q <= 1'b0;
      cnt_q <= 4'h0;
      shift_q <= 8'h00;
      ev_q <= '0;
    end else if (ce) begin
      scl_s1_q <= scl_in;
      scl_s2_q <= scl_s1_q;
      scl_p_q <= scl_s2_q;
      sda_s1_q <= sda_in;
      sda_s2_q <= sda_s1_q;
      sda_p_q <= sda_s2_q;
      active_q <= active_d;
      cnt_q <= cnt_d;
      shift_q <= shift_d;
      ev_q <= ev_d;
    end
  end

endmodule
`default_nettype wire

// >>> rtl/i2c_addr_wake.sv
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Ten-bit own address, upper bits reserved
// - Prefix 11110AA: compare AA with address top
// - Second byte compared with address low eight
// - Seven-bit mode uses low seven bits only
// - Mask one means don't care, zero exact
// - Any address equal on unmasked bits matches
// - Wake only when wake enable set
// - Select: data toggle or address match wakes
// - Wake flag set when woken
// - Flag cleared only by writing one
// - Ten-bit matching only when enabled
module i2c_addr_wake (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic power_down,
  output logic wake_req,
  output logic addr_match,
  output logic irq
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_FIRST = 4'b0010,
    ST_SECOND = 4'b0100,
    ST_DONE = 4'b1000
  } match_state_t;
  addr_wake_pkg::rx_event_t ev;
  addr_wake_pkg::match_cfg_t cfg_q, cfg_d;
  match_state_t st_q, st_d;
  logic aw_held_q, aw_held_d, w_held_q, w_held_d, bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [7:0] awaddr_q, awaddr_d, raddr_q, raddr_d;
  logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d, rd_word, wbits;
  logic [3:0] wstrb_q, wstrb_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d, irq_sts_q, irq_sts_d, irq_msk_q, irq_msk_d;
  logic wr_fire, wr_hit, rd_hit, wake_flag_q, wake_flag_d, wake_req_q, wake_req_d, irq_q, irq_d;
  logic match_q, match_d, addressed_q, addressed_d, rw_q, rw_d;
  logic wake_set, wake_trig, first_hit7, first_hit10, second_hit;
  i2c_byte_rx u_rx (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .rx_ev(ev)
  );
  function automatic logic masked_eq(input logic [9:0] rx, input logic [9:0] own,
                                     input logic [9:0] msk);
    masked_eq = ((rx ^ own) & ~msk) == 10'h000;
  endfunction
  function automatic logic [9:0] lanes(input logic [9:0] old, input logic [31:0] d,
                                       input logic [3:0] s);
    lanes = {s[1] ? d[9:8] : old[9:8], s[0] ? d[7:0] : old[7:0]};
  endfunction
  // Register bus
  assign awready = !aw_held_q && !bvalid_q;
  assign wready = !w_held_q && !bvalid_q;
  assign arready = !rvalid_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign wr_fire = aw_held_q && w_held_q && !bvalid_q;
  assign wbits = wdata_q & {{16{1'b0}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  always_comb begin
    case (awaddr_q[7:2])
      addr_wake_pkg::OWN_ADDR_OFS[7:2], addr_wake_pkg::ADDR_MASK_OFS[7:2],
      addr_wake_pkg::WAKE_CTL_OFS[7:2], addr_wake_pkg::WAKE_STS_OFS[7:2],
      addr_wake_pkg::PROT_CTL_OFS[7:2], addr_wake_pkg::IRQ_STS_OFS[7:2],
      addr_wake_pkg::IRQ_MSK_OFS[7:2], addr_wake_pkg::MATCH_STS_OFS[7:2]: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end
  always_comb begin
    rd_hit = 1'b1;
    rd_word = 32'h0000_0000;
    case (araddr[7:2])
      addr_wake_pkg::OWN_ADDR_OFS[7:2]: rd_word[9:0] = cfg_q.own;
      addr_wake_pkg::ADDR_MASK_OFS[7:2]: rd_word[9:0] = cfg_q.mask;
      addr_wake_pkg::WAKE_CTL_OFS[7:2]: begin
        rd_word[addr_wake_pkg::WAKE_EN_BIT] = cfg_q.wake_en;
        rd_word[addr_wake_pkg::WAKE_SEL_BIT] = cfg_q.wake_sel;
      end
      addr_wake_pkg::WAKE_STS_OFS[7:2]: rd_word[addr_wake_pkg::WAKE_FLAG_BIT] = wake_flag_q;
      addr_wake_pkg::PROT_CTL_OFS[7:2]: rd_word[addr_wake_pkg::TEN_EN_BIT] = cfg_q.ten_en;
      addr_wake_pkg::IRQ_STS_OFS[7:2]: rd_word[1:0] = irq_sts_q;
      addr_wake_pkg::IRQ_MSK_OFS[7:2]: rd_word[1:0] = irq_msk_q;
      addr_wake_pkg::MATCH_STS_OFS[7:2]: begin
        rd_word[addr_wake_pkg::MATCH_ADDRESSED_BIT] = addressed_q;
        rd_word[addr_wake_pkg::MATCH_RW_BIT] = rw_q;
      end
      default: rd_hit = 1'b0;
    endcase
  end
  always_comb begin
    aw_held_d = aw_held_q;
    awaddr_d = awaddr_q;
    w_held_d = w_held_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    raddr_d = raddr_q;
    if (awvalid && awready) begin
      aw_held_d = 1'b1;
      awaddr_d = awaddr;
    end
    if (wvalid && wready) begin
      w_held_d = 1'b1;
      wdata_d = wdata;
      wstrb_d = wstrb;
    end
    if (wr_fire) begin
      aw_held_d = 1'b0;
      w_held_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = wr_hit ? addr_wake_pkg::RESP_OKAY : addr_wake_pkg::RESP_SLVERR;
    end
    if (bvalid_q && bready) begin
      bvalid_d = 1'b0;
    end
    if (arvalid && arready) begin
      rvalid_d = 1'b1;
      rdata_d = rd_word;
      raddr_d = araddr;
      rresp_d = rd_hit ? addr_wake_pkg::RESP_OKAY : addr_wake_pkg::RESP_SLVERR;
    end else if (rvalid_q && rready) begin
      rvalid_d = 1'b0;
    end
  end
  // Configuration, wake and interrupt state
  always_comb begin
    cfg_d = cfg_q;
    irq_msk_d = irq_msk_q;
    if (wr_fire) begin
      case (awaddr_q[7:2])
        addr_wake_pkg::OWN_ADDR_OFS[7:2]: cfg_d.own = lanes(cfg_q.own, wdata_q, wstrb_q);
        addr_wake_pkg::ADDR_MASK_OFS[7:2]: cfg_d.mask = lanes(cfg_q.mask, wdata_q, wstrb_q);
        addr_wake_pkg::WAKE_CTL_OFS[7:2]: if (wstrb_q[0]) begin
          cfg_d.wake_en = wdata_q[addr_wake_pkg::WAKE_EN_BIT];
          cfg_d.wake_sel = wdata_q[addr_wake_pkg::WAKE_SEL_BIT];
        end
        addr_wake_pkg::PROT_CTL_OFS[7:2]: if (wstrb_q[0]) begin
          cfg_d.ten_en = wdata_q[addr_wake_pkg::TEN_EN_BIT];
        end
        addr_wake_pkg::IRQ_MSK_OFS[7:2]: if (wstrb_q[0]) begin
          irq_msk_d = wdata_q[1:0];
        end
        default: cfg_d = cfg_q;
      endcase
    end
  end
  assign wake_trig = cfg_q.wake_sel ? match_d : ev.sda_edge;
  assign wake_set = cfg_q.wake_en && power_down && wake_trig;
  always_comb begin
    wake_flag_d = wake_flag_q;
    irq_sts_d = irq_sts_q;
    if (wr_fire && awaddr_q[7:2] == addr_wake_pkg::WAKE_STS_OFS[7:2]) begin
      wake_flag_d = wake_flag_q & ~wbits[addr_wake_pkg::WAKE_FLAG_BIT];
    end
    if (wr_fire && awaddr_q[7:2] == addr_wake_pkg::IRQ_STS_OFS[7:2]) begin
      irq_sts_d = irq_sts_q & ~wbits[1:0];
    end
    // Set wins over a clear in the same cycle
    if (wake_set) begin
      wake_flag_d = 1'b1;
      irq_sts_d[addr_wake_pkg::IRQ_WAKE_BIT] = 1'b1;
    end
    if (match_d) begin
      irq_sts_d[addr_wake_pkg::IRQ_MATCH_BIT] = 1'b1;
    end
    wake_req_d = wake_set;
    irq_d = |(irq_sts_d & irq_msk_d);
  end
  // Address recognition
  assign first_hit7 = masked_eq({3'h0, ev.data[7:1]}, {3'h0, cfg_q.own[6:0]},
                                {3'h0, cfg_q.mask[6:0]});
  assign first_hit10 = ev.data[7:3] == addr_wake_pkg::TEN_PREFIX &&
                       masked_eq({ev.data[2:1], 8'h00}, {cfg_q.own[9:8], 8'h00},
                                 {cfg_q.mask[9:8], 8'h00});
  assign second_hit = masked_eq({2'h0, ev.data}, {2'h0, cfg_q.own[7:0]},
                                {2'h0, cfg_q.mask[7:0]});
  always_comb begin
    st_d = st_q;
    match_d = 1'b0;
    addressed_d = addressed_q;
    rw_d = rw_q;
    if (ev.stop) begin
      st_d = ST_IDLE;
      addressed_d = 1'b0;
    end else if (ev.start) begin
      st_d = ST_FIRST;
      addressed_d = 1'b0;
    end else if (ev.byte_valid) begin
      case (st_q)
        ST_FIRST: begin
          rw_d = ev.data[0];
          st_d = ST_DONE;
          if (cfg_q.ten_en && first_hit10) begin
            st_d = ST_SECOND;
          end else if (!cfg_q.ten_en && first_hit7) begin
            match_d = 1'b1;
          end
        end
        ST_SECOND: begin
          st_d = ST_DONE;
          match_d = second_hit;
        end
        ST_IDLE, ST_DONE: st_d = st_q;
        default: st_d = ST_IDLE;
      endcase
    end
    if (match_d) begin
      addressed_d = 1'b1;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      awaddr_q <= 8'h00;
      w_held_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= addr_wake_pkg::RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= addr_wake_pkg::RESP_OKAY;
      raddr_q <= 8'h00;
      cfg_q <= {addr_wake_pkg::WAKE_CTL_RST, 1'b0, addr_wake_pkg::OWN_ADDR_RST,
                addr_wake_pkg::ADDR_MASK_RST};
      irq_msk_q <= addr_wake_pkg::IRQ_RST;
      irq_sts_q <= addr_wake_pkg::IRQ_RST;
      wake_flag_q <= 1'b0;
      wake_req_q <= 1'b0;
      irq_q <= 1'b0;
      st_q <= ST_IDLE;
      match_q <= 1'b0;
      addressed_q <= 1'b0;
      rw_q <= 1'b0;
    end else if (ce) begin
      aw_held_q <= aw_held_d;
      awaddr_q <= awaddr_d;
      w_held_q <= w_held_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      raddr_q <= raddr_d;
      cfg_q <= cfg_d;
      irq_msk_q <= irq_msk_d;
      irq_sts_q <= irq_sts_d;
      wake_flag_q <= wake_flag_d;
      wake_req_q <= wake_req_d;
      irq_q <= irq_d;
      st_q <= st_d;
      match_q <= match_d;
      addressed_q <= addressed_d;
      rw_q <= rw_d;
    end
  end
  assign wake_req = wake_req_q;
  assign addr_match = match_q;
  assign irq = irq_q;
  default clocking cb @(posedge aclk iff ce);
  endclocking
  default disable iff (!aresetn);
  property p_own_reserved;
    rvalid_q && raddr_q[7:2] == addr_wake_pkg::OWN_ADDR_OFS[7:2] |-> rdata_q[31:10] == 22'h0;
  endproperty
  a_own_reserved: assert property (p_own_reserved) else $error("own address high bits set");
  property p_ten_prefix;
    st_q == ST_FIRST && ev.byte_valid && !ev.start && !ev.stop && cfg_q.ten_en &&
      ev.data[7:3] == addr_wake_pkg::TEN_PREFIX &&
      ((ev.data[2:1] ^ cfg_q.own[9:8]) & ~cfg_q.mask[9:8]) == 2'h0 |=> st_q == ST_SECOND;
  endproperty
  a_ten_prefix: assert property (p_ten_prefix) else $error("ten-bit prefix not taken");
  property p_ten_second;
    st_q == ST_SECOND && ev.byte_valid && !ev.start && !ev.stop &&
      ((ev.data ^ cfg_q.own[7:0]) & ~cfg_q.mask[7:0]) == 8'h00 |=> match_q && addressed_q;
  endproperty
  a_ten_second: assert property (p_ten_second) else $error("second byte match missed");
  property p_seven_match;
    st_q == ST_FIRST && ev.byte_valid && !ev.start && !ev.stop && !cfg_q.ten_en |=>
      match_q == $past(((ev.data[7:1] ^ cfg_q.own[6:0]) & ~cfg_q.mask[6:0]) == 7'h00);
  endproperty
  a_seven_match: assert property (p_seven_match) else $error("seven-bit match wrong");
  property p_ten_no_seven;
    cfg_q.ten_en && st_q == ST_FIRST && ev.byte_valid |=> !match_q;
  endproperty
  a_ten_no_seven: assert property (p_ten_no_seven) else $error("first byte matched in ten-bit");
  property p_wake_off;
    !cfg_q.wake_en && !wake_flag_q && !(wr_fire) |=> !wake_flag_q ##1 !wake_req_q;
  endproperty
  a_wake_off: assert property (p_wake_off) else $error("wake while disabled");
  property p_wake_toggle;
    cfg_q.wake_en && !cfg_q.wake_sel && power_down && ev.sda_edge |=> wake_flag_q && wake_req_q;
  endproperty
  a_wake_toggle: assert property (p_wake_toggle) else $error("toggle wake missed");
  property p_wake_match_only;
    cfg_q.wake_sel && !match_d && !wake_flag_q |=> !wake_flag_q;
  endproperty
  a_wake_match_only: assert property (p_wake_match_only) else $error("wake without match");
  property p_flag_sticky;
    wake_flag_q && !(wr_fire && awaddr_q[7:2] == addr_wake_pkg::WAKE_STS_OFS[7:2] &&
      wstrb_q[0] && wdata_q[0]) |=> wake_flag_q;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("wake flag lost");
endmodule
`default_nettype wire

// >>> bench/i2c_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
  output logic scl,
  output logic sda
);
  // Quarter of a bit period; 80 ns gives the 320 ns link clock
  int hp = 80;
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // Off-grid start keeps the link out of phase with aclk
  task automatic start_c();
    #7;
    sda = 1'b0;
    #(hp);
    scl = 1'b0;
    #(hp);
  endtask
  task automatic put_bit(input logic b);
    sda = b;
    #(hp);
    scl = 1'b1;
    #(2 * hp);
    scl = 1'b0;
    #(hp);
  endtask
  // Eight bits MSB first, then the ack clock with the line left to its pull-up
  task automatic xfer(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      put_bit(b[i]);
    end
    put_bit(1'b1);
  endtask
  task automatic stop_c();
    sda = 1'b0;
    #(hp);
    scl = 1'b1;
    #(hp);
    sda = 1'b1;
    #(2 * hp);
  endtask
  // Data line toggle with the clock standing high
  task automatic toggle();
    #7;
    sda = 1'b0;
    #(4 * hp);
    sda = 1'b1;
    #(4 * hp);
  endtask
endmodule
`default_nettype wire

// >>> bench/i2c_addr_wake_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module i2c_addr_wake_tb_top;
  logic aclk, aresetn, ce, awvalid, wvalid, bready, arvalid, rready, power_down;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rdat;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  logic awready, wready, bvalid, arready, rvalid, wake_req, addr_match, irq;
  wire logic scl, sda;
  int n_mismatch = 0;
  int checks_done = 0;
  int n_match = 0;
  int n_wake = 0;

  i2c_addr_wake uut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .scl_in(scl), .sda_in(sda), .power_down(power_down),
    .wake_req(wake_req), .addr_match(addr_match), .irq(irq));
  i2c_master_model mst (.scl(scl), .sda(sda));

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    if (addr_match === 1'b1) n_match++;
    if (wake_req === 1'b1) n_wake++;
  end

  task automatic summarize();
    $display("checks %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic tmo();
    n_mismatch++;
    $display("wrong value at %0t: got %h expected %h", $time, 1'b0, 1'b1);
    summarize();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    if (k == 50) tmo();
    resp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    int k;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    if (k == 50) tmo();
    rdat = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    `CHK(rdat, e)
  endtask
  task automatic frame(input logic [7:0] b1, input logic [7:0] b2, input bit two, input int e);
    int m0;
    m0 = n_match;
    mst.start_c();
    mst.xfer(b1);
    if (two) mst.xfer(b2);
    mst.stop_c();
    repeat (8) @(posedge aclk);
    `CHK(n_match - m0, e)
  endtask

  task automatic t_regs();
    rchk(addr_wake_pkg::OWN_ADDR_OFS, 32'h0);
    rchk(addr_wake_pkg::ADDR_MASK_OFS, 32'h0);
    rchk(addr_wake_pkg::WAKE_CTL_OFS, 32'h0);
    rchk(addr_wake_pkg::WAKE_STS_OFS, 32'h0);
    wr(addr_wake_pkg::OWN_ADDR_OFS, 32'hffffffff);
    rchk(addr_wake_pkg::OWN_ADDR_OFS, 32'h3ff);
    wr(addr_wake_pkg::ADDR_MASK_OFS, 32'hffffffff);
    rchk(addr_wake_pkg::ADDR_MASK_OFS, 32'h3ff);
    wr(addr_wake_pkg::WAKE_CTL_OFS, 32'hffffffff);
    rchk(addr_wake_pkg::WAKE_CTL_OFS, 32'h3);
    wr(8'h70, 32'h1);
    `CHK(resp, addr_wake_pkg::RESP_SLVERR)
    rchk(8'h70, 32'h0);
    `CHK(resp, addr_wake_pkg::RESP_SLVERR)
    wr(addr_wake_pkg::ADDR_MASK_OFS, 32'h0);
    wr(addr_wake_pkg::WAKE_CTL_OFS, 32'h0);
    $display("test regs done");
  endtask
  task automatic t_seven();
    wr(addr_wake_pkg::OWN_ADDR_OFS, 32'h2a5);
    frame(8'h4a, 8'h0, 0, 1);
    frame(8'h4b, 8'h0, 0, 1);
    rchk(addr_wake_pkg::MATCH_STS_OFS, 32'h2);
    frame(8'h48, 8'h0, 0, 0);
    wr(addr_wake_pkg::ADDR_MASK_OFS, 32'h1);
    frame(8'h48, 8'h0, 0, 1);
    wr(addr_wake_pkg::ADDR_MASK_OFS, 32'h0);
    $display("test seven done");
  endtask
  task automatic t_ten();
    wr(addr_wake_pkg::PROT_CTL_OFS, 32'h10);
    frame(8'hf4, 8'ha5, 1, 1);
    frame(8'hf2, 8'ha5, 1, 0);
    frame(8'hf4, 8'ha4, 1, 0);
    frame(8'h4a, 8'h0, 0, 0);
    frame(8'hf5, 8'ha5, 1, 1);
    wr(addr_wake_pkg::ADDR_MASK_OFS, 32'h200);
    frame(8'hf0, 8'ha5, 1, 1);
    wr(addr_wake_pkg::ADDR_MASK_OFS, 32'h0);
    wr(addr_wake_pkg::PROT_CTL_OFS, 32'h0);
    frame(8'hf4, 8'ha5, 1, 0);
    $display("test ten done");
  endtask
  task automatic t_wake();
    int w0;
    power_down <= 1'b1;
    w0 = n_wake;
    mst.toggle();
    repeat (8) @(posedge aclk);
    `CHK(n_wake - w0, 0)
    rchk(addr_wake_pkg::WAKE_STS_OFS, 32'h0);
    wr(addr_wake_pkg::WAKE_CTL_OFS, 32'h1);
    mst.toggle();
    repeat (8) @(posedge aclk);
    `CHK(n_wake > w0, 1'b1)
    rchk(addr_wake_pkg::WAKE_STS_OFS, 32'h1);
    frame(8'h48, 8'h0, 0, 0);
    rchk(addr_wake_pkg::WAKE_STS_OFS, 32'h1);
    wr(addr_wake_pkg::WAKE_STS_OFS, 32'h0);
    rchk(addr_wake_pkg::WAKE_STS_OFS, 32'h1);
    wr(addr_wake_pkg::WAKE_STS_OFS, 32'h1);
    rchk(addr_wake_pkg::WAKE_STS_OFS, 32'h0);
    wr(addr_wake_pkg::WAKE_CTL_OFS, 32'h3);
    w0 = n_wake;
    frame(8'h48, 8'h0, 0, 0);
    `CHK(n_wake - w0, 0)
    frame(8'h4a, 8'h0, 0, 1);
    `CHK(n_wake - w0, 1)
    rchk(addr_wake_pkg::WAKE_STS_OFS, 32'h1);
    wr(addr_wake_pkg::WAKE_STS_OFS, 32'h1);
    wr(addr_wake_pkg::WAKE_CTL_OFS, 32'h0);
    power_down <= 1'b0;
    $display("test wake done");
  endtask
  task automatic t_irq();
    wr(addr_wake_pkg::IRQ_STS_OFS, 32'h3);
    wr(addr_wake_pkg::IRQ_MSK_OFS, 32'h1);
    repeat (2) @(posedge aclk);
    `CHK(irq, 1'b0)
    frame(8'h4a, 8'h0, 0, 1);
    rchk(addr_wake_pkg::IRQ_STS_OFS, 32'h1);
    `CHK(irq, 1'b1)
    wr(addr_wake_pkg::IRQ_MSK_OFS, 32'h0);
    repeat (2) @(posedge aclk);
    `CHK(irq, 1'b0)
    wr(addr_wake_pkg::IRQ_MSK_OFS, 32'h1);
    repeat (2) @(posedge aclk);
    `CHK(irq, 1'b1)
    wr(addr_wake_pkg::IRQ_STS_OFS, 32'h1);
    repeat (2) @(posedge aclk);
    `CHK(irq, 1'b0)
    $display("test irq done");
  endtask
  // Frozen block must ignore a whole frame, then match again
  task automatic t_ce();
    ce <= 1'b0;
    frame(8'h4a, 8'h0, 0, 0);
    ce <= 1'b1;
    repeat (2) @(posedge aclk);
    frame(8'h4a, 8'h0, 0, 1);
    $display("test ce done");
  endtask

  initial begin
    aresetn = 1'b0;
    ce = 1'b1;
    awaddr = 8'h0;
    araddr = 8'h0;
    wdata = 32'h0;
    wstrb = 4'h0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    power_down = 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_seven();
    t_ten();
    t_wake();
    t_irq();
    t_ce();
    summarize();
  end
endmodule
`default_nettype wire
